//--- logic/scsc_top.sv
// How it works
// - one of four start sources selected
// - software busy write starts conversion
// - third timer overflow starts conversion
// - external rising edge starts conversion
// - second timer overflow starts conversion
// - busy high during conversion, cleared after
// - busy fall after the last repeat sets done, raises interrupt
// - result valid whenever done reads one
// - timer low or high overflow by mode
// - powered when enabled or while a conversion runs
// - burst powers up, accumulates, shuts down
// - twenty-seven single-ended input selections
// - five-bit select field, one temperature code
// - twelve-bit SAR with accumulator
// - right or left justified result
// - tracking mode codes select tracking
// - thirteen SAR ticks plus two cycles
// - post-start tracking plus two cycles
// - burst repeat count before done
`timescale 1ns/1ps
module scsc_top
	import scsc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        tmr2LowOvf,
	input  wire logic        tmr2HighOvf,
	input  wire logic        tmr2Split8,
	input  wire logic        tmr3LowOvf,
	input  wire logic        tmr3HighOvf,
	input  wire logic        tmr3Split8,
	input  wire logic        extConvStart,
	input  wire logic        cmpHigh,
	output logic      [11:0] sarTrial,
	output logic      [4:0]  inputSelect,
	output logic             tempSensorOn,
	output logic             trackSwitchOn,
	output logic             converterPowered,
	output logic             convIrq
);

	// Reset release through two flops; assertion stays asynchronous
	logic rstMeta_ff;
	logic rstN_ff;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_ff <= 1'b0;
			rstN_ff    <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstN_ff    <= rstMeta_ff;
		end
	end

	scsc_eng_if engIf ();

	scsc_sar_engine u_engine (
		.sys_clk (sys_clk),
		.rstN    (rstN_ff),
		.cmpHigh (cmpHigh),
		.eng     (engIf)
	);

	logic [15:0] ctrl_ff, nxt_ctrl;
	logic [4:0]  mux_ff, nxt_mux;
	logic [4:0]  div_ff, nxt_div;
	logic [15:0] res_ff, nxt_res;
	logic        done_ff, nxt_done;
	logic        extPrev_ff;
	logic        wait_ff, nxt_wait;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        irq_ff, nxt_irq;
	logic        pwr_ff, nxt_pwr;
	logic        temp_ff, nxt_temp;

	logic [31:0] wmask;
	logic [15:0] wctrl;
	logic        take;
	logic        wrCtrl;
	logic        swStart;
	logic        extRise;
	logic        t2Ovf;
	logic        t3Ovf;
	logic        trig;
	logic        startReq;
	logic        doneClear;

	// Start source selection and trigger qualification
	always_comb begin
		take    = (avs_read || avs_write) && !wait_ff;
		wrCtrl  = take && avs_write && (avs_address == ADDR_CTRL) &&
			avs_byteenable[0];
		// a one written to busy with software source
		swStart = wrCtrl && avs_writedata[CB_BUSY];
		// rising edge only, level and fall ignored
		extRise = extConvStart && !extPrev_ff;
		// low-byte overflow in split mode, else high byte
		t2Ovf   = tmr2Split8 ? tmr2LowOvf : tmr2HighOvf;
		t3Ovf   = tmr3Split8 ? tmr3LowOvf : tmr3HighOvf;
		// exactly one source feeds the start
		case (ctrl_ff[CB_SRC +: 2])
			SRC_SW:  trig = swStart;
			SRC_T3:  trig = t3Ovf;
			SRC_EXT: trig = extRise;
			SRC_T2:  trig = t2Ovf;
			default: trig = 1'b0;
		endcase
		// starts during a conversion are dropped
		startReq = trig && !engIf.busy &&
			(ctrl_ff[CB_EN] || ctrl_ff[CB_BURST]);
	end

	assign engIf.start      = startReq;
	assign engIf.trackMode  = ctrl_ff[CB_TM +: 2];
	assign engIf.trackTime  = ctrl_ff[CB_TK +: 4];
	assign engIf.sarDiv     = div_ff;
	assign engIf.repeatCode = ctrl_ff[CB_RPT +: 2];
	assign engIf.burst      = ctrl_ff[CB_BURST];

	// Register file, status and bus answer
	always_comb begin
		wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wctrl = (ctrl_ff & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
		nxt_ctrl  = ctrl_ff;
		nxt_mux   = mux_ff;
		nxt_div   = div_ff;
		nxt_res   = res_ff;
		nxt_rdata = rdata_ff;
		doneClear = wrCtrl && !avs_writedata[CB_DONE];
		// One wait cycle per access, then a one-cycle answer
		nxt_wait  = !((avs_read || avs_write) && wait_ff);
		if (take && avs_write) begin
			case (avs_address)
				ADDR_CTRL: nxt_ctrl = wctrl & CTRL_CFG_MASK;
				ADDR_MUX: begin
					// codes past the last selection ignored
					if (avs_byteenable[0] && avs_writedata[4:0] <= MUX_LAST)
						nxt_mux = avs_writedata[MUX_W-1:0];
				end
				ADDR_DIV: begin
					if (avs_byteenable[0])
						nxt_div = avs_writedata[4:0];
				end
				default: nxt_ctrl = ctrl_ff;
			endcase
		end
		if (avs_read && wait_ff) begin
			case (avs_address)
				ADDR_CTRL: nxt_rdata = {16'h0000, ctrl_ff[15:5], done_ff,
					engIf.busy, ctrl_ff[2:0]};
				ADDR_MUX:  nxt_rdata = {27'h0000000, mux_ff};
				ADDR_RES:  nxt_rdata = {16'h0000, res_ff};
				ADDR_DIV:  nxt_rdata = {27'h0000000, div_ff};
				default:   nxt_rdata = 32'h00000000;
			endcase
		end
		// completion sets done; set beats clear
		nxt_done = done_ff;
		if (doneClear)
			nxt_done = 1'b0;
		if (engIf.allDone)
			nxt_done = 1'b1;
		if (engIf.allDone) begin
			// left justify a single 12-bit result
			if (ctrl_ff[CB_LJ] && ctrl_ff[CB_RPT +: 2] == 2'h0)
				nxt_res = {engIf.accum[11:0], 4'h0};
			else
				nxt_res = engIf.accum;
		end
		nxt_irq  = nxt_done && nxt_ctrl[CB_IE];
		// powered by enable or a running conversion
		nxt_pwr  = nxt_ctrl[CB_EN] || engIf.busy;
		nxt_temp = (nxt_mux == MUX_TEMP);
	end

	always_ff @(posedge sys_clk or negedge rstN_ff) begin
		if (!rstN_ff) begin
			ctrl_ff    <= CTRL_RST;
			mux_ff     <= MUX_RST;
			div_ff     <= DIV_RST;
			res_ff     <= '0;
			done_ff    <= 1'b0;
			extPrev_ff <= 1'b0;
			wait_ff    <= 1'b1;
			rdata_ff   <= '0;
			irq_ff     <= 1'b0;
			pwr_ff     <= 1'b0;
			temp_ff    <= 1'b0;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			mux_ff     <= nxt_mux;
			div_ff     <= nxt_div;
			res_ff     <= nxt_res;
			done_ff    <= nxt_done;
			extPrev_ff <= extConvStart;
			wait_ff    <= nxt_wait;
			rdata_ff   <= nxt_rdata;
			irq_ff     <= nxt_irq;
			pwr_ff     <= nxt_pwr;
			temp_ff    <= nxt_temp;
		end
	end

	// Outputs straight from flops
	assign avs_readdata     = rdata_ff;
	assign avs_waitrequest  = wait_ff;
	assign sarTrial         = engIf.trial;
	assign inputSelect      = mux_ff;
	assign tempSensorOn     = temp_ff;
	assign trackSwitchOn    = engIf.trackOn;
	assign converterPowered = pwr_ff;
	assign convIrq          = irq_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstN_ff);

	sequence idleReady;
		!engIf.busy && (ctrl_ff[CB_EN] || ctrl_ff[CB_BURST]);
	endsequence

	sw_start_a: assert property (
		(idleReady and (ctrl_ff[CB_SRC +: 2] == SRC_SW && swStart))
			|=> engIf.busy)
		else $error("software start lost");
	t3_start_a: assert property (
		(idleReady and (ctrl_ff[CB_SRC +: 2] == SRC_T3 && tmr3Split8 &&
			tmr3LowOvf)) |=> engIf.busy)
		else $error("third timer start lost");
	ext_edge_a: assert property (
		(ctrl_ff[CB_SRC +: 2] == SRC_EXT && startReq) |->
			extConvStart && $past(extConvStart) == 1'b0)
		else $error("external start without rising edge");
	t2_start_a: assert property (
		(idleReady and (ctrl_ff[CB_SRC +: 2] == SRC_T2 && !tmr2Split8 &&
			tmr2HighOvf)) |=> engIf.busy)
		else $error("second timer start lost");
	busy_ignore_a: assert property (
		engIf.busy |-> !startReq)
		else $error("start accepted while busy");
	done_sets_a: assert property (
		engIf.allDone |=> done_ff && res_ff == $past(nxt_res) ##1 irq_ff ==
			(done_ff && ctrl_ff[CB_IE]) || !done_ff)
		else $error("completion did not set done");
	irq_gate_a: assert property (
		(done_ff && ctrl_ff[CB_IE]) |=> irq_ff || !done_ff || !ctrl_ff[CB_IE])
		else $error("interrupt not raised");
	power_down_a: assert property (
		(!nxt_ctrl[CB_EN] && !engIf.busy) |=> !converterPowered)
		else $error("converter powered while idle");
	bus_answer_a: assert property (
		((avs_read || avs_write) && wait_ff) |=> !avs_waitrequest ##1
			avs_waitrequest)
		else $error("bus answer timing wrong");

endmodule // scsc_top

//--- logic/scsc_pkg.sv
package scsc_pkg;

	// Register byte addresses, one aligned word each
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_MUX  = 4'h4;
	localparam logic [3:0] ADDR_RES  = 4'h8;
	localparam logic [3:0] ADDR_DIV  = 4'hC;

	// Control register fields
	localparam int CB_EN     = 0;
	localparam int CB_SRC    = 1;
	localparam int CB_BUSY   = 3;
	localparam int CB_DONE   = 4;
	localparam int CB_IE     = 5;
	localparam int CB_BURST  = 6;
	localparam int CB_TM     = 7;
	localparam int CB_LJ     = 9;
	localparam int CB_RPT    = 10;
	localparam int CB_TK     = 12;
	localparam int CTRL_W    = 16;

	// Busy and done are live state, never stored as configuration
	localparam logic [15:0] CTRL_CFG_MASK = 16'hFFE7;
	localparam logic [15:0] CTRL_RST      = 16'h0000;

	// Start source codes
	localparam logic [1:0] SRC_SW  = 2'h0;
	localparam logic [1:0] SRC_T3  = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	localparam logic [1:0] SRC_T2  = 2'h3;

	// Tracking mode codes
	localparam logic [1:0] TM_POST = 2'h1;
	localparam logic [1:0] TM_PRE  = 2'h2;
	localparam logic [1:0] TM_DUAL = 2'h3;

	// Input selector
	localparam int         MUX_W    = 5;
	localparam logic [4:0] MUX_TEMP = 5'h18;
	localparam logic [4:0] MUX_LAST = 5'h1A;
	localparam logic [4:0] MUX_RST  = 5'h00;

	// Converter timing, in subsystem clock cycles or SAR ticks
	localparam int         SAR_BITS    = 12;
	localparam logic [3:0] SAR_LAST    = 4'hC;
	localparam logic [4:0] TRACK_EXTRA = 5'h02;
	localparam logic [4:0] DIV_RST     = 5'h01;
	localparam int         ACC_W       = 16;

	typedef enum logic [2:0] {
		ST_IDLE, ST_TRACK, ST_START, ST_CONV, ST_FINISH
	} scsc_state_t;

	// Repeat code to number of accumulated conversions
	function automatic logic [4:0] scscRptTotal(input logic [1:0] c);
		case (c)
			2'h0: scscRptTotal = 5'h01;
			2'h1: scscRptTotal = 5'h04;
			2'h2: scscRptTotal = 5'h08;
			default: scscRptTotal = 5'h10;
		endcase
	endfunction

endpackage

//--- logic/scsc_eng_if.sv
`timescale 1ns/1ps
interface scsc_eng_if;
	logic        start;
	logic [1:0]  trackMode;
	logic [3:0]  trackTime;
	logic [4:0]  sarDiv;
	logic [1:0]  repeatCode;
	logic        burst;
	logic        busy;
	logic        allDone;
	logic        trackOn;
	logic [11:0] trial;
	logic [15:0] accum;

	modport ctl (output start, trackMode, trackTime, sarDiv, repeatCode,
		burst, input busy, allDone, trackOn, trial, accum);
	modport eng (input start, trackMode, trackTime, sarDiv, repeatCode,
		burst, output busy, allDone, trackOn, trial, accum);
endinterface

//--- logic/scsc_sar_engine.sv
`timescale 1ns/1ps
module scsc_sar_engine
	import scsc_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rstN,
	input  wire logic cmpHigh,
	scsc_eng_if.eng   eng
);

	scsc_state_t       state_ff, nxt_state;
	logic [4:0]        trk_ff, nxt_trk;
	logic [4:0]        div_ff, nxt_div;
	logic [3:0]        sar_ff, nxt_sar;
	logic [3:0]        rpt_ff, nxt_rpt;
	logic [11:0]       trial_ff, nxt_trial;
	logic [ACC_W-1:0]  acc_ff, nxt_acc;
	logic              busy_ff, nxt_busy;
	logic              done_ff, nxt_done;
	logic              trk_on_ff, nxt_trk_on;
	logic [3:0]        pos;
	logic [4:0]        total;

	// Sequencer: track, start cycle, 13 SAR ticks, finish cycle
	always_comb begin
		nxt_state = state_ff;
		nxt_trk   = trk_ff;
		nxt_div   = div_ff;
		nxt_sar   = sar_ff;
		nxt_rpt   = rpt_ff;
		nxt_trial = trial_ff;
		nxt_acc   = acc_ff;
		nxt_done  = 1'b0;
		total     = scscRptTotal(eng.repeatCode);
		pos       = SAR_LAST - sar_ff;
		case (state_ff)
			ST_IDLE: begin
				if (eng.start) begin
					if (rpt_ff == 4'h0)
						nxt_acc = '0;
					nxt_trk = {1'b0, eng.trackTime} + TRACK_EXTRA;
					nxt_state = (eng.trackMode == TM_PRE) ? ST_START : ST_TRACK;
				end
			end
			ST_TRACK: begin
				if (trk_ff <= 5'h01)
					nxt_state = ST_START;
				else
					nxt_trk = trk_ff - 5'h01;
			end
			ST_START: begin
				nxt_div   = '0;
				nxt_sar   = '0;
				nxt_state = ST_CONV;
			end
			ST_CONV: begin
				// divider gives one SAR tick per sarDiv+1 cycles
				if (div_ff == eng.sarDiv) begin
					nxt_div = '0;
					// sample tick, then one bit decided per tick
					if (sar_ff == 4'h0) begin
						nxt_trial = 12'h800;
					end else begin
						if (!cmpHigh)
							nxt_trial[pos] = 1'b0;
						if (pos != 4'h0)
							nxt_trial[pos - 4'h1] = 1'b1;
					end
					if (sar_ff == SAR_LAST)
						nxt_state = ST_FINISH;
					else
						nxt_sar = sar_ff + 4'h1;
				end else begin
					nxt_div = div_ff + 5'h01;
				end
			end
			ST_FINISH: begin
				nxt_acc = acc_ff + {4'h0, trial_ff};
				// done only after the whole repeat count
				if ({1'b0, rpt_ff} == total - 5'h01) begin
					nxt_rpt   = '0;
					nxt_done  = 1'b1;
					nxt_state = ST_IDLE;
				end else begin
					nxt_rpt = rpt_ff + 4'h1;
					nxt_trk = {1'b0, eng.trackTime} + TRACK_EXTRA;
					// burst runs on without further starts
					nxt_state = eng.burst ? ST_TRACK : ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		nxt_busy = (nxt_state != ST_IDLE);
		// sampling switch follows the tracking mode
		// Code 0 behaves as post: switch open while idle
		case (eng.trackMode)
			TM_POST, 2'h0: nxt_trk_on = (nxt_state == ST_TRACK);
			default: nxt_trk_on = (nxt_state == ST_TRACK) ||
				(nxt_state == ST_IDLE);
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			state_ff  <= ST_IDLE;
			trk_ff    <= '0;
			div_ff    <= '0;
			sar_ff    <= '0;
			rpt_ff    <= '0;
			trial_ff  <= '0;
			acc_ff    <= '0;
			busy_ff   <= 1'b0;
			done_ff   <= 1'b0;
			trk_on_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			trk_ff    <= nxt_trk;
			div_ff    <= nxt_div;
			sar_ff    <= nxt_sar;
			rpt_ff    <= nxt_rpt;
			trial_ff  <= nxt_trial;
			acc_ff    <= nxt_acc;
			busy_ff   <= nxt_busy;
			done_ff   <= nxt_done;
			trk_on_ff <= nxt_trk_on;
		end
	end

	assign eng.busy    = busy_ff;
	assign eng.allDone = done_ff;
	assign eng.trackOn = trk_on_ff;
	assign eng.trial   = trial_ff;
	assign eng.accum   = acc_ff;

	// Helper counters for the timing checks
	logic [7:0] convLen_ff;
	logic [4:0] trkLen_ff;
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			convLen_ff <= '0;
			trkLen_ff  <= '0;
		end else begin
			convLen_ff <= (state_ff == ST_CONV) ? convLen_ff + 8'h01 : 8'h00;
			trkLen_ff  <= (state_ff == ST_TRACK) ? trkLen_ff + 5'h01 : 5'h00;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstN);

	sequence convExit;
		(state_ff == ST_CONV) ##1 (state_ff == ST_FINISH);
	endsequence
	sequence trackExit;
		(state_ff == ST_TRACK) ##1 (state_ff == ST_START);
	endsequence

	conv_length_a: assert property (
		convExit |-> convLen_ff ==
			8'(13 * ({3'h0, eng.sarDiv} + 8'h01)))
		else $error("conversion length wrong");
	track_length_a: assert property (
		trackExit |-> trkLen_ff == 5'($past(trk_ff, 1) + trkLen_ff - 5'h01)
			&& trkLen_ff == {1'b0, eng.trackTime} + TRACK_EXTRA)
		else $error("tracking length wrong");
	repeat_done_a: assert property (
		nxt_done |-> {1'b0, rpt_ff} == total - 5'h01)
		else $error("done before repeat count");
	busy_span_a: assert property (
		(state_ff == ST_FINISH && nxt_done) |=> !busy_ff && done_ff)
		else $error("busy not cleared at completion");

endmodule // scsc_sar_engine

//--- bench/scsc_far_model.sv
`timescale 1ns/1ps
// Far side of the converter: two timers, the start pin and the comparator
module scsc_far_model (
	input  wire logic        sys_clk,
	input  wire logic [11:0] sarTrial,
	output logic             tmr2LowOvf,
	output logic             tmr2HighOvf,
	output logic             tmr2Split8,
	output logic             tmr3LowOvf,
	output logic             tmr3HighOvf,
	output logic             tmr3Split8,
	output logic             extConvStart,
	output logic             cmpHigh
);
	logic [3:0]  ovf;
	logic [11:0] level;

	// Overflow lines, index 0..3 is t2 low, t2 high, t3 low, t3 high
	assign {tmr3HighOvf, tmr3LowOvf, tmr2HighOvf, tmr2LowOvf} = ovf;
	// Input sits half a code above level, so the search lands on level
	assign cmpHigh = (level >= sarTrial);

	// Quiet start, no overflow or pin activity
	initial begin
		ovf          = 4'h0;
		level        = 12'h000;
		tmr2Split8   = 1'b0;
		tmr3Split8   = 1'b0;
		extConvStart = 1'b0;
	end

	// One-cycle overflow pulse, as a real timer gives
	task automatic pulse(input int idx);
		@(posedge sys_clk);
		ovf[idx] <= 1'b1;
		@(posedge sys_clk);
		ovf <= 4'h0;
	endtask

	// Timer width modes, level signals
	task automatic setSplit(input logic t2, input logic t3);
		@(posedge sys_clk);
		tmr2Split8 <= t2;
		tmr3Split8 <= t3;
	endtask

	// pin kept for start only
	// Start pin level, held until told otherwise
	task automatic setPin(input logic v);
		@(posedge sys_clk);
		extConvStart <= v;
	endtask
endmodule // scsc_far_model

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench
	import scsc_pkg::*;
;
	logic sys_clk, nrst, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic t2l, t2h, t2s, t3l, t3h, t3s, extConvStart, cmpHigh;
	logic [11:0] sarTrial;
	logic [4:0]  inputSelect;
	logic tempSensorOn, trackSwitchOn, converterPowered, convIrq;
	int          error_cnt = 0;
	int          checked   = 0;
	integer      seed      = 32'h9DF1C3E9;
	logic [31:0] expQ[$];
	logic [31:0] mskQ[$];

	// 100 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	scsc_top scsc_top_inst (.sys_clk(sys_clk), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tmr2LowOvf(t2l),
		.tmr2HighOvf(t2h), .tmr2Split8(t2s), .tmr3LowOvf(t3l),
		.tmr3HighOvf(t3h), .tmr3Split8(t3s), .extConvStart(extConvStart),
		.cmpHigh(cmpHigh), .sarTrial(sarTrial), .inputSelect(inputSelect),
		.tempSensorOn(tempSensorOn), .trackSwitchOn(trackSwitchOn),
		.converterPowered(converterPowered), .convIrq(convIrq));

	scsc_far_model scsc_far_model_inst (.sys_clk(sys_clk),
		.sarTrial(sarTrial), .tmr2LowOvf(t2l), .tmr2HighOvf(t2h),
		.tmr2Split8(t2s), .tmr3LowOvf(t3l), .tmr3HighOvf(t3h),
		.tmr3Split8(t3s), .extConvStart(extConvStart), .cmpHigh(cmpHigh));

	task automatic wrap_up();
		if (error_cnt == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h want %h", $time, msg,
				got, exp);
		end
	endtask

	// A hung wait counts as a mismatch and ends the run
	task automatic hang(input string msg);
		error_cnt++;
		$display("wrong value at %0t: %s timed out", $time, msg);
		wrap_up();
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic busCyc(input logic [3:0] a, input logic wr,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
			hang("bus");
	endtask

	// Note the expected answer, then read
	task automatic rdChk(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m);
		expQ.push_back(e & m);
		mskQ.push_back(m);
		busCyc(a, 1'b0, 32'h0);
	endtask

	// Read answers are compared against the oldest note
	always @(posedge sys_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (expQ.size() == 0)
				chk(32'h1, 32'h0, "unexpected read");
			else
				chk(avs_readdata & mskQ.pop_front(), expQ.pop_front(), "read");
		end
	end

	// Cycles from the call until the interrupt shows
	task automatic waitIrq(input int e);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (convIrq !== 1'b1 && n < 3000);
		if (n >= 3000)
			hang("irq");
		if (e > 0)
			chk(n, e, "latency");
	endtask

	// Control word with interrupt enabled, busy and done written 0
	function automatic logic [15:0] cfg(input logic [1:0] src,
		input logic [1:0] tm, input logic bst, input logic [1:0] rpt,
		input logic lj, input logic [3:0] tk, input logic en);
		cfg = {tk, rpt, lj, tm, bst, 1'b1, 2'b00, src, en};
	endfunction

	// Taking edge to interrupt: start, ticks, finish, flag, plus tracking
	function automatic int lat(input logic [1:0] tm, input logic [3:0] tk,
		input logic [4:0] dv);
		lat = 3 + 13 * (dv + 1) + ((tm == TM_PRE) ? 0 : tk + 2);
	endfunction

	// Store the word first; a start obeys the stored source and enables
	task automatic swGo(input logic [15:0] c);
		busCyc(ADDR_CTRL, 1'b1, {16'h0, c});
		busCyc(ADDR_CTRL, 1'b1, {16'h0, c | 16'h0008});
	endtask

	// Finish one conversion: result, sticky flag, then clear it
	task automatic runOne(input logic [15:0] c, input int e,
		input logic [15:0] res);
		waitIrq(e);
		rdChk(ADDR_RES, {16'h0, res}, 32'hFFFF);
		rdChk(ADDR_CTRL, {16'h0, c | 16'h0010}, 32'hFFFF);
		busCyc(ADDR_CTRL, 1'b1, {16'h0, c});
		rdChk(ADDR_CTRL, {16'h0, c}, 32'hFFFF);
	endtask

	// Main sequence
	initial begin
		logic [15:0] c;
		logic [4:0]  dv;
		logic [3:0]  tk;
		logic [11:0] v;
		{nrst, avs_read, avs_write, avs_address} = '0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hF;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// Reset values, unmapped place, input selector
		rdChk(ADDR_CTRL, CTRL_RST, 32'hFFFF);
		rdChk(ADDR_DIV, DIV_RST, 32'h1F);
		rdChk(ADDR_MUX, MUX_RST, 32'h1F);
		busCyc(4'h2, 1'b1, 32'hFFFF);
		rdChk(4'h2, 32'h0, 32'hFFFFFFFF);
		busCyc(ADDR_MUX, 1'b1, MUX_TEMP);
		rdChk(ADDR_MUX, MUX_TEMP, 32'h1F);
		chk(tempSensorOn, 1'b1, "temp select");
		busCyc(ADDR_MUX, 1'b1, MUX_LAST + 5'h01);
		rdChk(ADDR_MUX, MUX_TEMP, 32'h1F);
		busCyc(ADDR_MUX, 1'b1, MUX_LAST);
		@(posedge sys_clk);
		chk({tempSensorOn, inputSelect}, {1'b0, MUX_LAST}, "select");
		// Software starts in every tracking mode code, random timing
		for (int i = 0; i < 4; i++) begin
			dv = {3'h0, 2'($random(seed))};
			tk = 4'($random(seed));
			v = 12'($random(seed));
			scsc_far_model_inst.level <= v;
			c = cfg(SRC_SW, i[1:0], 1'b0, 2'h0, i == 2, tk, 1'b1);
			busCyc(ADDR_DIV, 1'b1, {27'h0, dv});
			swGo(c);
			if (i == 1)
				busCyc(ADDR_CTRL, 1'b1, {16'h0, c | 16'h0008});
			else
				rdChk(ADDR_CTRL, {16'h0, c | 16'h0008}, 32'hFFFF);
			runOne(c, lat(i[1:0], tk, dv) - 3,
				(i == 2) ? {v, 4'h0} : {4'h0, v});
			chk(trackSwitchOn, i[1], "idle track switch");
		end
		// Refused start while off; masked interrupt
		c = cfg(SRC_SW, TM_PRE, 1'b0, 2'h0, 1'b0, 4'h0, 1'b0);
		swGo(c);
		repeat (40) @(posedge sys_clk);
		rdChk(ADDR_CTRL, {16'h0, c}, 32'hFFFF);
		chk(converterPowered, 1'b0, "shutdown");
		c = cfg(SRC_SW, TM_PRE, 1'b0, 2'h0, 1'b0, 4'h0, 1'b1) & 16'hFFDF;
		swGo(c);
		repeat (80) @(posedge sys_clk);
		chk(convIrq, 1'b0, "masked irq");
		rdChk(ADDR_CTRL, {16'h0, c | 16'h0010}, 32'hFFFF);
		// Hardware sources; wrong width, other timer, pin level ignored
		scsc_far_model_inst.setSplit(1'b0, 1'b1);
		for (int s = 0; s < 3; s++) begin
			c = cfg((s == 0) ? SRC_T3 : (s == 1) ? SRC_T2 : SRC_EXT, TM_PRE,
				1'b0, 2'h0, 1'b0, 4'h0, 1'b1);
			busCyc(ADDR_CTRL, 1'b1, {16'h0, c});
			if (s < 2) begin
				scsc_far_model_inst.pulse((s == 0) ? 3 : 0);
				scsc_far_model_inst.pulse((s == 0) ? 1 : 2);
				repeat (40) @(posedge sys_clk);
				rdChk(ADDR_CTRL, {16'h0, c}, 32'hFFFF);
				scsc_far_model_inst.pulse((s == 0) ? 2 : 1);
			end else
				scsc_far_model_inst.setPin(1'b1);
			runOne(c, 0, {4'h0, v});
		end
		scsc_far_model_inst.setPin(1'b0);
		repeat (40) @(posedge sys_clk);
		rdChk(ADDR_CTRL, {16'h0, c}, 32'hFFFF);
		// Burst with every repeat count, enable bit off
		for (int r = 0; r < 4; r++) begin
			// Dual tracking only, pre mode is not allowed with burst
			c = cfg(SRC_SW, TM_DUAL, 1'b1, r[1:0], 1'b0, 4'h1, 1'b0);
			swGo(c);
			repeat (4) @(posedge sys_clk);
			chk(converterPowered, 1'b1, "burst power");
			runOne(c, 0, 16'(v * ((r == 0) ? 1 : (4 << (r - 1)))));
			chk(converterPowered, 1'b0, "burst off");
		end
		wrap_up();
	end
endmodule // testbench
